// >>> rtl/control_word_pkg.sv
// Constants, field layouts and reset values for the control word decoder.
// Assumes words arrive already framed, one 16-bit word per strobe.
// Operation
// RULE1: Range code 100/101/110 selects 4-20/0-20/0-24 mA
// RULE2: All-on bit powers every regulator together
// RULE3: Top bits 100 mean software register write
// RULE4: Toggle bit D12 copied to status bit
// RULE5: Code 0x555 performs full software reset
// RULE6: Host sends 0x195 before each timeout
// RULE7: Missed keep-alive raises the fault alert
// RULE8: Top bits 011 update regulator control fields
// RULE9: Phase field sets channel clock edge offsets
// RULE10: Frequency field picks 250/410/650 kHz switching
// RULE11: Voltage field limits boost 23-29.5 V
// RULE12: Other codes only update toggle bit
package control_word_pkg;

  localparam int          WORD_W         = 16;
  localparam int          CHANNELS       = 4;
  localparam int          CMD_MSB        = 15;
  localparam int          CMD_LSB        = 13;
  localparam logic [2:0]  CMD_SOFTWARE   = 3'h4;
  localparam logic [2:0]  CMD_REGULATOR  = 3'h3;

  localparam int          TOGGLE_BIT     = 12;
  localparam int          CODE_MSB       = 11;
  localparam int          STATUS_TOGGLE_BIT = 11;
  localparam logic [11:0] CODE_RESET     = 12'h555;
  localparam logic [11:0] CODE_KEEPALIVE = 12'h195;

  localparam int          COMP_BIT       = 6;
  localparam int          PHASE_LSB      = 4;
  localparam int          FREQ_LSB       = 2;
  localparam int          VMAX_LSB       = 0;

  localparam logic        COMP_RESET     = 1'b0;
  localparam logic [1:0]  PHASE_RESET    = 2'h0;
  localparam logic [1:0]  FREQ_RESET     = 2'h1;
  localparam logic [1:0]  VMAX_RESET     = 2'h0;

  localparam logic [2:0]  RANGE_4_20     = 3'h4;
  localparam logic [2:0]  RANGE_0_20     = 3'h5;
  localparam logic [2:0]  RANGE_0_24     = 3'h6;

  typedef enum logic [3:0] {
    RANGE_NONE = 4'b0001,
    RANGE_I4T20 = 4'b0010,
    RANGE_I0T20 = 4'b0100,
    RANGE_I0T24 = 4'b1000
  } range_e;

  localparam int          CLK_HZ         = 100_000_000;
  localparam int          FREQ_250_HZ    = 250_000;
  localparam int          FREQ_410_HZ    = 410_000;
  localparam int          FREQ_650_HZ    = 650_000;
  localparam int          PERIOD_W       = 10;
  localparam logic [9:0]  PERIOD_250     = 10'(CLK_HZ / FREQ_250_HZ);
  localparam logic [9:0]  PERIOD_410     = 10'(CLK_HZ / FREQ_410_HZ);
  localparam logic [9:0]  PERIOD_650     = 10'(CLK_HZ / FREQ_650_HZ);

  // Boost limits in tenths of a volt
  localparam logic [8:0]  VMAX_23_0      = 9'h0E6;
  localparam logic [8:0]  VMAX_24_5      = 9'h0F5;
  localparam logic [8:0]  VMAX_27_0      = 9'h10E;
  localparam logic [8:0]  VMAX_29_5      = 9'h127;

  localparam int          WDOG_W         = 24;

endpackage : control_word_pkg

// >>> rtl/keepalive_watchdog.sv
// Interface watchdog: counts down between keep-alive writes.
// Assumes timeout is held stable while enabled.
module keepalive_watchdog
  import control_word_pkg::*;
#(
  parameter int CNT_W = WDOG_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] timeout,
  input  wire logic             kick,
  input  wire logic             clear,
  output logic                  fault
);

  if (CNT_W < 2) begin : g_bad_width
    $error("keepalive_watchdog: CNT_W too small");
  end

  typedef enum logic [2:0] {
    WD_IDLE  = 3'b001,
    WD_RUN   = 3'b010,
    WD_FAULT = 3'b100
  } wd_state_e;

  wd_state_e        state_r;
  wd_state_e        state_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  wire expired = (count_r == '0);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      WD_IDLE: begin
        count_nxt = timeout;
        if (enable) state_nxt = WD_RUN;
      end
      WD_RUN: begin
        if (!enable) begin
          state_nxt = WD_IDLE;
        end else if (kick) begin
          count_nxt = timeout;
        end else if (expired) begin
          state_nxt = WD_FAULT; // RULE7
        end else begin
          count_nxt = count_r - 1'b1;
        end
      end
      WD_FAULT: begin
        // Alert holds until a keep-alive, a disable or a clear
        if (!enable) state_nxt = WD_IDLE;
        else if (kick) begin
          state_nxt = WD_RUN;
          count_nxt = timeout;
        end
      end
      default: state_nxt = WD_IDLE;
    endcase
    if (clear) begin
      state_nxt = WD_IDLE;
      count_nxt = timeout;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= WD_IDLE;
      count_r <= '0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign fault = (state_r == WD_FAULT); // RULE7

endmodule : keepalive_watchdog

// >>> rtl/control_word_decode.sv
// Decoder for framed 16-bit control words: software register and regulator control.
// Assumes the serial framer delivers one word per wordValid pulse, synchronous to clk_sys.
module control_word_decode
  import control_word_pkg::*;
#(
  parameter int NUM_CH = CHANNELS,
  parameter int WD_W   = WDOG_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             wordValid,
  input  wire logic [WORD_W-1:0] serial_data_in,
  input  wire logic [2:0]       range_select [NUM_CH],
  input  wire logic [NUM_CH-1:0] channelRegulatorOn,
  input  wire logic             regulators_all_on,
  input  wire logic             watchdogEnable,
  input  wire logic [WD_W-1:0]  watchdogTimeout,
  output range_e                rangeActive [NUM_CH],
  output logic [NUM_CH-1:0]     regulatorPower,
  output logic [NUM_CH-1:0]     regulatorClock,
  output logic                  comp_resistor_select,
  output logic [1:0]            regulator_phase,
  output logic [1:0]            regulator_frequency,
  output logic [1:0]            boost_voltage_limit,
  output logic [8:0]            boostLimitDecivolt,
  output logic [WORD_W-1:0]     statusWord,
  output logic                  softReset,
  output logic                  faultAlert
);

  // Elaboration checks
  if (NUM_CH != 4) begin : g_bad_channels
    $error("control_word_decode: phase scheme serves four channels only");
  end
  if (WD_W < 2) begin : g_bad_wdog
    $error("control_word_decode: WD_W too small");
  end

  function automatic range_e decodeRange(input logic [2:0] code);
    range_e r;
    r = RANGE_NONE;
    if (code == RANGE_4_20) r = RANGE_I4T20;
    else if (code == RANGE_0_20) r = RANGE_I0T20;
    else if (code == RANGE_0_24) r = RANGE_I0T24;
    return r;
  endfunction : decodeRange

  // Command decode
  wire [2:0]  cmdField   = serial_data_in[CMD_MSB:CMD_LSB];
  wire [11:0] codeField  = serial_data_in[CODE_MSB:0];
  wire        swWrite    = wordValid && (cmdField == CMD_SOFTWARE);   // RULE3
  wire        regWrite   = wordValid && (cmdField == CMD_REGULATOR);  // RULE8
  wire        resetCode  = swWrite && (codeField == CODE_RESET);      // RULE5
  wire        keepAlive  = swWrite && (codeField == CODE_KEEPALIVE);  // RULE6 RULE12

  logic       toggle_r;
  logic       comp_r;
  logic [1:0] phase_r;
  logic [1:0] freq_r;
  logic [1:0] vmax_r;
  logic       softReset_r;
  range_e     range_r [NUM_CH];
  logic [NUM_CH-1:0] power_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      toggle_r <= 1'b0;
    end else if (swWrite) begin
      toggle_r <= serial_data_in[TOGGLE_BIT]; // RULE4 RULE12
    end
  end

  // Reset code returns the regulator fields to defaults; its own toggle bit is still copied to toggle_r
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comp_r  <= COMP_RESET;
      phase_r <= PHASE_RESET;
      freq_r  <= FREQ_RESET;
      vmax_r  <= VMAX_RESET;
    end else if (resetCode) begin
      comp_r  <= COMP_RESET; // RULE5
      phase_r <= PHASE_RESET;
      freq_r  <= FREQ_RESET;
      vmax_r  <= VMAX_RESET;
    end else if (regWrite) begin
      comp_r  <= serial_data_in[COMP_BIT]; // RULE8
      phase_r <= serial_data_in[PHASE_LSB+1:PHASE_LSB];
      freq_r  <= serial_data_in[FREQ_LSB+1:FREQ_LSB];
      vmax_r  <= serial_data_in[VMAX_LSB+1:VMAX_LSB];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) softReset_r <= 1'b0;
    else softReset_r <= resetCode; // RULE5
  end

  // Range and power outputs registered
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire range_e rangeNxt = decodeRange(range_select[g]); // RULE1
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) range_r[g] <= RANGE_NONE;
        else range_r[g] <= rangeNxt;
      end
      assign rangeActive[g] = range_r[g];
    end
  endgenerate

  wire [NUM_CH-1:0] powerNxt = channelRegulatorOn | {NUM_CH{regulators_all_on}}; // RULE2

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) power_r <= '0;
    else power_r <= powerNxt;
  end

  // Switching clock; 250 kHz also serves the unlisted code 11
  wire [PERIOD_W-1:0] period =
    (freq_r == 2'h0) ? PERIOD_250 :
    (freq_r == 2'h1) ? PERIOD_410 :
    (freq_r == 2'h2) ? PERIOD_650 : PERIOD_250; // RULE10

  wire [PERIOD_W-1:0] halfP    = period >> 1;
  wire [PERIOD_W-1:0] quarterP = period >> 2;

  logic [PERIOD_W-1:0] phaseCnt_r;
  logic [PERIOD_W-1:0] phaseCnt_nxt;

  // Counter restart on frequency change keeps the compare in range
  logic [1:0] freqSeen_r;
  wire        phaseWrap   = (phaseCnt_r >= period - 1'b1);
  wire        freqChanged = (freqSeen_r != freq_r);
  assign phaseCnt_nxt = (phaseWrap || freqChanged) ? '0 : phaseCnt_r + 1'b1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phaseCnt_r <= '0;
      freqSeen_r <= FREQ_RESET;
    end else begin
      phaseCnt_r <= phaseCnt_nxt;
      freqSeen_r <= freq_r;
    end
  end

  // Channel offset as multiples of a quarter period
  function automatic logic [1:0] quarterOffset(input logic [1:0] ph, input int ch);
    logic [1:0] q;
    q = 2'h0;
    case (ph)
      2'h1: q = (ch >= 2) ? 2'h2 : 2'h0;
      2'h2: q = (ch == 1 || ch == 3) ? 2'h2 : 2'h0;
      2'h3: q = 2'(ch);
      default: q = 2'h0;
    endcase
    return q;
  endfunction : quarterOffset

  logic [NUM_CH-1:0] regClk_r;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_clk
      // Sum stays below two periods, so one wrap suffices
      wire [1:0]          q      = quarterOffset(phase_r, g); // RULE9
      wire [PERIOD_W+1:0] offs   = PERIOD_W'(q) * quarterP;
      wire [PERIOD_W+1:0] sum    = {2'b00, phaseCnt_r} + offs;
      wire [PERIOD_W+1:0] wrap   = (sum >= {2'b00, period}) ? sum - {2'b00, period} : sum;
      wire                clkNxt = power_r[g] && (wrap < {2'b00, halfP});
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) regClk_r[g] <= 1'b0;
        else regClk_r[g] <= clkNxt;
      end
    end
  endgenerate

  // Limit registered with its code so the data output comes from a flip-flop
  function automatic logic [8:0] limitDecivolt(input logic [1:0] code);
    logic [8:0] v;
    v = VMAX_29_5;
    if (code == 2'h0) v = VMAX_23_0;
    else if (code == 2'h1) v = VMAX_24_5;
    else if (code == 2'h2) v = VMAX_27_0;
    return v;
  endfunction : limitDecivolt

  logic [8:0] boostLimit_r;
  wire  [8:0] boostLimitNxt = limitDecivolt(serial_data_in[VMAX_LSB+1:VMAX_LSB]); // RULE11

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boostLimit_r <= VMAX_23_0;
    end else if (resetCode) begin
      boostLimit_r <= VMAX_23_0; // RULE5
    end else if (regWrite) begin
      boostLimit_r <= boostLimitNxt; // RULE11
    end
  end

  // A reset word also drops a pending fault
  keepalive_watchdog #(
    .CNT_W (WD_W)
  ) u_wdog (
    .clk_sys (clk_sys),
    .rst     (rst),
    .enable  (watchdogEnable),
    .timeout (watchdogTimeout),
    .kick    (keepAlive),       // RULE6
    .clear   (resetCode),
    .fault   (faultAlert)       // RULE7
  );

  assign regulatorPower       = power_r;
  assign regulatorClock       = regClk_r;
  assign comp_resistor_select = comp_r;
  assign regulator_phase      = phase_r;
  assign regulator_frequency  = freq_r;
  assign boost_voltage_limit  = vmax_r;
  assign boostLimitDecivolt   = boostLimit_r;
  assign statusWord           = WORD_W'({toggle_r, {STATUS_TOGGLE_BIT{1'b0}}}); // RULE4
  assign softReset            = softReset_r;

endmodule : control_word_decode

// >>> verif/host_model.sv
// Host side of the word port: one framed word per call.
// Assumes the decoder samples words on rising clk_sys.
module host_model
  import control_word_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             wordValid,
  output logic [WORD_W-1:0] serial_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wordValid = 1'b0;
    serial_data_in = 16'h0000;
  end
  // Released data is inverted so stale words never look valid
  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge clk_sys);
    wordValid <= 1'b1;
    serial_data_in <= w;
    @(posedge clk_sys);
    wordValid <= 1'b0;
    serial_data_in <= ~w;
  endtask : send
endmodule : host_model

// >>> verif/control_word_decode_sva.sv
// Port checks for the control word decoder.
// Bound into each decoder; one clock domain.
module control_word_decode_sva
  import control_word_pkg::*;
#(parameter int NUM_CH = CHANNELS) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              wordValid,
  input wire logic [15:0]       serial_data_in,
  input wire logic [2:0]        range_select [NUM_CH],
  input wire logic [NUM_CH-1:0] channelRegulatorOn,
  input wire logic              regulators_all_on,
  input wire logic              watchdogEnable,
  input wire range_e            rangeActive [NUM_CH],
  input wire logic [NUM_CH-1:0] regulatorPower,
  input wire logic              comp_resistor_select,
  input wire logic [1:0]        regulator_phase,
  input wire logic [1:0]        regulator_frequency,
  input wire logic [1:0]        boost_voltage_limit,
  input wire logic [8:0]        boostLimitDecivolt,
  input wire logic [15:0]       statusWord,
  input wire logic              softReset,
  input wire logic              faultAlert
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [2:0]        top = serial_data_in[CMD_MSB:CMD_LSB];
  wire logic [11:0]       code = serial_data_in[CODE_MSB:0];
  wire logic              sw = wordValid && top == CMD_SOFTWARE;
  wire logic              rg = wordValid && top == CMD_REGULATOR;
  wire logic              rs = sw && code == CODE_RESET;
  wire logic [NUM_CH-1:0] pw = channelRegulatorOn | {NUM_CH{regulators_all_on}};
  wire logic [6:0]        fld = {comp_resistor_select, regulator_phase, regulator_frequency, boost_voltage_limit};
  wire range_e            rx = range_select[0] == RANGE_4_20 ? RANGE_I4T20 : range_select[0] == RANGE_0_20 ?
    RANGE_I0T20 : range_select[0] == RANGE_0_24 ? RANGE_I0T24 : RANGE_NONE;
  wire logic [8:0]        vx = boost_voltage_limit == 2'h0 ? VMAX_23_0 : boost_voltage_limit == 2'h1 ?
    VMAX_24_5 : boost_voltage_limit == 2'h2 ? VMAX_27_0 : VMAX_29_5;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_range; !$past(rst) |-> rangeActive[0] == $past(rx); endproperty
  a_range: assert property (p_range)
    else $error("range decode wrong");
  property p_power; !$past(rst) |-> regulatorPower == $past(pw); endproperty
  a_power: assert property (p_power)
    else $error("regulator power wrong");
  property p_tog; sw |=> statusWord[STATUS_TOGGLE_BIT] == $past(serial_data_in[TOGGLE_BIT]); endproperty
  a_tog: assert property (p_tog)
    else $error("toggle bit not mirrored");
  property p_srst; rs |=> softReset; endproperty
  a_srst: assert property (p_srst)
    else $error("reset code without reset");
  property p_srsrc; softReset |-> $past(rs); endproperty
  a_srsrc: assert property (p_srsrc)
    else $error("reset without reset code");
  property p_reg; rg |=> fld == $past(serial_data_in[6:0]); endproperty
  a_reg: assert property (p_reg)
    else $error("regulator fields wrong");
  property p_hold; !rg && !rs |=> $stable(fld); endproperty
  a_hold: assert property (p_hold)
    else $error("regulator fields changed");
  property p_boost; boostLimitDecivolt == vx; endproperty
  a_boost: assert property (p_boost)
    else $error("boost limit wrong");
  property p_kick; sw && code == CODE_KEEPALIVE && watchdogEnable |=> !faultAlert; endproperty
  a_kick: assert property (p_kick)
    else $error("fault after keep-alive");
  property p_fault; $rose(faultAlert) |-> $past(watchdogEnable); endproperty
  a_fault: assert property (p_fault)
    else $error("fault while disabled");
  c_rs: cover property (rs);
  c_rg: cover property (rg);
  c_fault: cover property ($rose(faultAlert));
endmodule : control_word_decode_sva

bind control_word_decode control_word_decode_sva #(.NUM_CH(NUM_CH)) sva (.clk_sys, .rst, .wordValid,
  .serial_data_in, .range_select, .channelRegulatorOn, .regulators_all_on, .watchdogEnable, .rangeActive,
  .regulatorPower, .comp_resistor_select, .regulator_phase, .regulator_frequency, .boost_voltage_limit,
  .boostLimitDecivolt, .statusWord, .softReset, .faultAlert);

// >>> verif/testbench.sv
// Self-checking bench for the control word decoder.
// Host model sends words; a monitor checks each taken word.
`define CHK(n, s, e) begin compares++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench
  import control_word_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         TMO = 5;
  localparam logic [6:0] DEF = {COMP_RESET, PHASE_RESET, FREQ_RESET, VMAX_RESET};
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        wordValid;
  logic [15:0] serial_data_in;
  logic [2:0]  range_select [CHANNELS] = '{default: 3'h0};
  logic [3:0]  channelRegulatorOn = 4'h0;
  logic        regulators_all_on = 0;
  logic        watchdogEnable = 0;
  logic [23:0] watchdogTimeout = 24'(TMO);
  range_e      rangeActive [CHANNELS];
  logic [3:0]  regulatorPower, regulatorClock;
  logic        comp_resistor_select, softReset, faultAlert, tog = 0, taken = 0;
  logic [1:0]  regulator_phase, regulator_frequency, boost_voltage_limit;
  logic [8:0]  boostLimitDecivolt;
  logic [15:0] statusWord;
  logic [6:0]  fld = DEF;
  logic [23:0] e;
  logic [23:0] expQ [$];
  logic [8:0]  vt [4] = '{VMAX_23_0, VMAX_24_5, VMAX_27_0, VMAX_29_5};
  int          bad_count = 0;
  int          compares = 0;
  wire logic [6:0] regv = {comp_resistor_select, regulator_phase, regulator_frequency, boost_voltage_limit};
  always #5 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .wordValid, .serial_data_in);
  control_word_decode DUT (.clk_sys, .rst, .wordValid, .serial_data_in, .range_select,
    .channelRegulatorOn, .regulators_all_on, .watchdogEnable, .watchdogTimeout, .rangeActive,
    .regulatorPower, .regulatorClock, .comp_resistor_select, .regulator_phase, .regulator_frequency,
    .boost_voltage_limit, .boostLimitDecivolt, .statusWord, .softReset, .faultAlert);
  task automatic put(input logic [15:0] w);
    logic sr;
    sr = w[15:13] == CMD_SOFTWARE && w[11:0] == CODE_RESET;
    if (w[15:13] == CMD_SOFTWARE) tog = w[12];
    if (sr) fld = DEF;
    if (w[15:13] == CMD_REGULATOR) fld = w[6:0];
    expQ.push_back({4'h0, tog, 11'h000, sr, fld});
    host.send(w);
  endtask : put
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic time_fault(input int t);
    int n;
    n = 0;
    @(posedge clk_sys);
    watchdogTimeout <= 24'(t);
    watchdogEnable <= 1;
    while (faultAlert !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("wdog", n, t + 2)
    if (n == 50) report_and_stop();
  endtask : time_fault
  always @(posedge clk_sys) taken <= wordValid;
  always @(negedge clk_sys) begin
    if (taken === 1'b1) begin
      e = expQ.pop_front();
      `CHK("word", {statusWord, softReset, regv}, e)
    end
  end
  initial begin
    logic [15:0] w;
    logic [3:0]  p;
    logic [9:0]  hi;
    logic [9:0]  pr;
    int          m;
    void'($urandom(32'hbf0a_793b));
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    #1 `CHK("dflt", regv, DEF)
    `CHK("boost0", boostLimitDecivolt, VMAX_23_0)
    for (int c = 0; c < 8; c++) begin
      p = 4'($urandom);
      @(posedge clk_sys);
      range_select[0] <= 3'(c);
      channelRegulatorOn <= p;
      regulators_all_on <= c[0];
      @(posedge clk_sys);
      #1 `CHK("range", rangeActive[0], c == 4 ? RANGE_I4T20 : c == 5 ? RANGE_I0T20 : c == 6 ? RANGE_I0T24 : RANGE_NONE)
      `CHK("power", regulatorPower, p | {4{c[0]}})
    end
    for (int k = 0; k < 4; k++) begin
      put({3'h3, 6'($urandom), 5'($urandom), 2'(k)});
      #1 `CHK("boost", boostLimitDecivolt, vt[k])
    end
    // Pairs share edges and opposite sides never overlap at 650 kHz
    @(posedge clk_sys);
    channelRegulatorOn <= 4'hF;
    for (int ph = 1; ph < 3; ph++) begin
      m = ph == 1 ? 1 : 2;
      put({3'h3, 6'h00, 1'b0, 2'(ph), 2'h2, 2'h0});
      repeat (4) @(posedge clk_sys);
      hi = '0;
      pr = '0;
      repeat (int'(PERIOD_650)) begin
        @(posedge clk_sys);
        #1 hi += 10'(regulatorClock[0]);
        pr += 10'((regulatorClock[0] ^ regulatorClock[m]) | (regulatorClock[3 - m] ^ regulatorClock[3]) |
          (regulatorClock[0] & regulatorClock[3 - m]));
      end
      `CHK("clkhigh", hi, 10'(PERIOD_650 >> 1))
      `CHK("clkphase", pr, 10'h000)
    end
    @(posedge clk_sys);
    channelRegulatorOn <= 4'h0;
    regulators_all_on <= 0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK("clkoff", regulatorClock, 4'h0)
    // Random mix covers every top code, ignored ones too
    repeat (40) begin
      w = 16'($urandom);
      if (w[15:13] == CMD_SOFTWARE && w[11:0] == CODE_KEEPALIVE) w[0] = 1'b0;
      put(w);
    end
    put(16'h9555);
    put(16'h8555);
    time_fault(TMO);
    put(16'h8123);
    #1 `CHK("stay", faultAlert, 1'b1)
    put(16'h8195);
    #1 `CHK("clear", faultAlert, 1'b0)
    repeat (6) put(16'h9195);
    #1 `CHK("alive", faultAlert, 1'b0)
    @(posedge clk_sys);
    watchdogEnable <= 0;
    repeat (20) @(posedge clk_sys);
    #1 `CHK("off", faultAlert, 1'b0)
    time_fault(TMO - 2);
    report_and_stop();
  end
endmodule : testbench
